// [hw/flash_ctl_defines.svh]
// Offsets, field positions, reset values and command codes of the flash control block.
// Assumes a 16-bit byte address space shared by the CPU and the debug host.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADDR_DIVIDER     16'h1820
`define ADDR_CONFIG      16'h1823
`define ADDR_PROTECT     16'h1824
`define ADDR_STATUS      16'h1825
`define ADDR_COMMAND     16'h1826
`define FLASH_BASE       16'h8000
`define KEY_BASE_HI      13'h1FF6
`define VEC_PAGE         10'h3FF
`define VEC_RESET_SLOT   5'h1F
`define REDIRECT_GAP     16'h0040

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFG_KEY_STEER    5
`define CFG_RW_MASK      8'hE0
`define PROT_OPEN        7
`define PROT_DISABLE     6
`define PROT_SIZE_HI     5
`define PROT_SIZE_LO     3
`define PROT_RW_MASK     8'hF8
`define ST_BUF_EMPTY     7
`define ST_COMPLETE      6
`define ST_VIOLATION     5
`define ST_ACC_ERROR     4
`define ST_BLANK         2

// ----------------------------------------------------------------------
// Reset values, sizes and command codes
// ----------------------------------------------------------------------
`define RST_BYTE         8'h00
`define BLOCK_MIN        16'h0200
`define SIZE_CAP_LARGE   3'h6
`define SIZE_CAP_SMALL   3'h4
`define CMD_BLANK        8'h05
`define CMD_BYTE_PROG    8'h20
`define CMD_BURST_PROG   8'h25
`define CMD_PAGE_ERASE   8'h40
`define CMD_MASS_ERASE   8'h41

`endif

// [hw/flash_ctl_pkg.sv]
// Types shared by the flash control block and its bench.
// Assumes flash_ctl_defines.svh holds every number.
package flash_ctl_pkg;

    // Command sequence position
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_DATA = 2'b01,
        SEQ_CMD  = 2'b10
    } seq_state_t;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] addr_t;

endpackage

// [hw/flash_control_status_regs.sv]
// Flash configuration, protection and status registers with command launch logic.
// Assumes a single bus clock; the array engine is modelled as a fixed cycle count.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

module flash_control_status_regs #(
    parameter bit          SMALL_FLASH = 1'b0,   // 1 for the 8K and 16K versions
    parameter int unsigned EXEC_CYCLES = 16      // Array busy time per command
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  ce_in,
    input  wire flash_ctl_pkg::addr_t  bus_addr_in,
    input  wire logic                  bus_wr_in,
    input  wire logic                  bus_rd_in,
    input  wire logic                  bus_debug_in,
    input  wire flash_ctl_pkg::byte_t  bus_wdata_in,
    output flash_ctl_pkg::byte_t       bus_rdata_out,
    input  wire flash_ctl_pkg::byte_t  stored_protection_byte_in,
    input  wire logic                  redirection_disable_in,
    input  wire logic                  secured_in,
    input  wire logic                  stop_entry_in,
    input  wire logic                  array_erased_in,
    input  wire flash_ctl_pkg::addr_t  vector_addr_in,
    output flash_ctl_pkg::addr_t       vector_addr_out,
    output logic                       flash_read_invalid_out,
    output logic                       key_write_out,
    output logic [2:0]                 key_index_out,
    output flash_ctl_pkg::byte_t       key_data_out,
    output logic                       array_start_out,
    output flash_ctl_pkg::byte_t       array_cmd_out,
    output flash_ctl_pkg::addr_t       array_addr_out,
    output flash_ctl_pkg::byte_t       array_data_out,
    output logic                       array_busy_out,
    output flash_ctl_pkg::byte_t       flash_clock_divider_out,
    output logic                       divider_loaded_out
);
    import flash_ctl_pkg::*;

    localparam int CW = $clog2(EXEC_CYCLES + 1);
    localparam logic [CW-1:0] EXEC_LAST = CW'(EXEC_CYCLES - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    byte_t      cfg_q, prot_q, div_q, rdata_q, key_data_q;
    byte_t      seq_cmd_q, seq_data_q, buf_cmd_q, buf_data_q, exe_cmd_q, exe_data_q;
    addr_t      seq_addr_q, buf_addr_q, exe_addr_q;
    seq_state_t seq_q, seq_d;
    logic       prot_load_q, div_loaded_q;
    logic       buf_empty_q, complete_q, viol_q, accerr_q, blank_q;
    logic       buf_full_q, busy_q, start_q, key_wr_q;
    logic [2:0] key_idx_q;
    logic [CW-1:0] cnt_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire hit_div   = bus_addr_in == `ADDR_DIVIDER;
    wire hit_cfg   = bus_addr_in == `ADDR_CONFIG;
    wire hit_prot  = bus_addr_in == `ADDR_PROTECT;
    wire hit_stat  = bus_addr_in == `ADDR_STATUS;
    wire hit_cmd   = bus_addr_in == `ADDR_COMMAND;
    wire hit_flash = bus_addr_in >= `FLASH_BASE;
    wire hit_key   = bus_addr_in[15:3] == `KEY_BASE_HI;
    wire key_steer = cfg_q[`CFG_KEY_STEER];

    // Key addresses turn into comparison writes only while steered
    wire key_wr    = bus_wr_in && hit_key && key_steer;
    // Any other flash write, key addresses included, is a command's first step
    wire flash_wr  = bus_wr_in && hit_flash && !key_wr;
    wire cmd_wr    = bus_wr_in && hit_cmd;
    wire stat_wr   = bus_wr_in && hit_stat;
    wire launch_wr = stat_wr && bus_wdata_in[`ST_BUF_EMPTY];

    // ------------------------------------------------------------------
    // Protected block geometry
    // ------------------------------------------------------------------
    wire [2:0] size_code = prot_q[`PROT_SIZE_HI:`PROT_SIZE_LO];
    // Large parts cap at 32K, small parts at 8K, so the block never runs off flash
    wire [2:0] size_cap  = SMALL_FLASH ? `SIZE_CAP_SMALL : `SIZE_CAP_LARGE;
    wire [2:0] size_eff  = (size_code > size_cap) ? size_cap : size_code;
    wire addr_t blk_size = `BLOCK_MIN << size_eff;
    wire addr_t blk_base = addr_t'(~(blk_size - 16'h0001));
    wire open_bit  = prot_q[`PROT_OPEN];
    wire block_on  = !prot_q[`PROT_DISABLE];

    // Open clear guards all of flash; otherwise only the block and security
    wire tgt_prot  = !open_bit || secured_in
                     || (block_on && seq_addr_q >= blk_base);
    wire mass_prot = !open_bit || secured_in || block_on;
    wire is_blank  = seq_cmd_q == `CMD_BLANK;
    wire is_burst  = seq_cmd_q == `CMD_BURST_PROG;
    wire is_mass   = seq_cmd_q == `CMD_MASS_ERASE;
    wire cmd_prot  = is_blank ? 1'b0 : (is_mass ? mass_prot : tgt_prot);

    // ------------------------------------------------------------------
    // Vector redirection
    // ------------------------------------------------------------------
    wire redir_on  = open_bit && block_on && !redirection_disable_in;
    wire addr_t redir_base = addr_t'(blk_base - `REDIRECT_GAP);
    wire vec_hit   = vector_addr_in[15:6] == `VEC_PAGE
                     && vector_addr_in[5:1] != `VEC_RESET_SLOT;
    assign vector_addr_out = (redir_on && vec_hit)
                             ? {redir_base[15:6], vector_addr_in[5:0]}
                             : vector_addr_in;

    // ------------------------------------------------------------------
    // Command code check and sequence tracking
    // ------------------------------------------------------------------
    wire code_ok = bus_wdata_in == `CMD_BLANK || bus_wdata_in == `CMD_BYTE_PROG
                   || bus_wdata_in == `CMD_BURST_PROG || bus_wdata_in == `CMD_PAGE_ERASE
                   || bus_wdata_in == `CMD_MASS_ERASE;

    // A launch with the buffer still full is refused silently
    wire launch_ok  = launch_wr && buf_empty_q;
    wire seq_err    = (flash_wr && seq_q != SEQ_IDLE)
                   || (cmd_wr && (seq_q != SEQ_DATA || !code_ok))
                   || (launch_ok && seq_q != SEQ_CMD)
                   || (launch_ok && seq_q == SEQ_CMD && !div_loaded_q);
    wire stop_err   = stop_entry_in && busy_q;
    wire good_launch = launch_ok && seq_q == SEQ_CMD && div_loaded_q;
    wire viol_set   = good_launch && cmd_prot;
    wire accept     = good_launch && !cmd_prot;

    // Sequence position: errors and launches return it to idle
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            SEQ_IDLE: if (flash_wr) seq_d = SEQ_DATA;
            SEQ_DATA: if (cmd_wr) seq_d = code_ok ? SEQ_CMD : SEQ_IDLE;
            SEQ_CMD:  if (launch_ok || flash_wr || cmd_wr) seq_d = SEQ_IDLE;
            default:  seq_d = SEQ_IDLE;
        endcase
        if (seq_err || stop_err) begin
            seq_d = SEQ_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Engine and one-deep burst buffer
    // ------------------------------------------------------------------
    wire exe_done  = busy_q && cnt_q == EXEC_LAST && !stop_err;
    // An accepted command goes straight to the array when idle or in the engine's last busy cycle, else to the buffer
    wire go_direct = accept && (!busy_q || exe_done) && !buf_full_q;
    wire to_buf    = accept && !go_direct;
    wire buf_move  = buf_full_q && exe_done;
    wire start     = go_direct || buf_move;
    wire busy_d    = start || (busy_q && !exe_done && !stop_err);
    wire buf_full_d = !stop_err && (to_buf || (buf_full_q && !buf_move));
    // Only a running burst can take another command behind it
    wire exe_burst = start ? (go_direct ? is_burst : buf_cmd_q == `CMD_BURST_PROG)
                           : exe_cmd_q == `CMD_BURST_PROG;
    wire buf_empty_d = !buf_full_d && (!busy_d || exe_burst);
    wire blank_set = exe_done && exe_cmd_q == `CMD_BLANK && array_erased_in;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    wire byte_t stat_rd = {buf_empty_q, complete_q, viol_q, accerr_q,
                           1'b0, blank_q, 2'b00};
    wire byte_t rd_mux  = hit_cfg  ? (cfg_q & `CFG_RW_MASK)
                        : hit_prot ? (prot_q & `PROT_RW_MASK)
                        : hit_stat ? stat_rd
                        : hit_div  ? {div_loaded_q, div_q[6:0]}
                        : hit_cmd  ? seq_cmd_q
                        : `RST_BYTE;

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Configuration keeps only its top three bits
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_q <= `RST_BYTE;
        end else if (ce_in && bus_wr_in && hit_cfg) begin
            cfg_q <= bus_wdata_in & `CFG_RW_MASK;
        end
    end

    // Protection loads from the stored copy right after every reset release;
    // a port value cannot feed the async reset branch, hence the load flag
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prot_q      <= `RST_BYTE;
            prot_load_q <= 1'b1;
        end else if (ce_in) begin
            prot_load_q <= 1'b0;
            if (prot_load_q) begin
                prot_q <= stored_protection_byte_in & `PROT_RW_MASK;
            end else if (bus_wr_in && hit_prot && bus_debug_in) begin
                prot_q <= bus_wdata_in & `PROT_RW_MASK;
            end
        end
    end

    // Divider value and its loaded flag
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_q        <= `RST_BYTE;
            div_loaded_q <= 1'b0;
        end else if (ce_in && bus_wr_in && hit_div) begin
            div_q        <= bus_wdata_in;
            div_loaded_q <= 1'b1;
        end
    end

    // Status flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_empty_q <= 1'b1;
            complete_q  <= 1'b1;
            viol_q      <= 1'b0;
            accerr_q    <= 1'b0;
            blank_q     <= 1'b0;
        end else if (ce_in) begin
            buf_empty_q <= buf_empty_d;
            complete_q  <= buf_empty_d && !busy_d && !accept;
            viol_q      <= viol_set
                        || (viol_q && !(stat_wr && bus_wdata_in[`ST_VIOLATION]));
            accerr_q    <= seq_err || stop_err
                        || (accerr_q && !(stat_wr && bus_wdata_in[`ST_ACC_ERROR]));
            blank_q     <= blank_set || (blank_q && !good_launch);
        end
    end

    // Sequence capture: address and data, then command code
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seq_q      <= SEQ_IDLE;
            seq_addr_q <= '0;
            seq_data_q <= `RST_BYTE;
            seq_cmd_q  <= `RST_BYTE;
        end else if (ce_in) begin
            seq_q <= seq_d;
            if (flash_wr && seq_q == SEQ_IDLE) begin
                seq_addr_q <= bus_addr_in;
                seq_data_q <= bus_wdata_in;
            end
            if (cmd_wr && seq_q == SEQ_DATA && code_ok) begin
                seq_cmd_q <= bus_wdata_in;
            end
        end
    end

    // Buffer slot holds one pending command queued behind a running burst
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            buf_full_q <= 1'b0;
            buf_cmd_q  <= `RST_BYTE;
            buf_addr_q <= '0;
            buf_data_q <= `RST_BYTE;
        end else if (ce_in) begin
            buf_full_q <= buf_full_d;
            if (to_buf) begin
                buf_cmd_q  <= seq_cmd_q;
                buf_addr_q <= seq_addr_q;
                buf_data_q <= seq_data_q;
            end
        end
    end

    // Array engine: fixed busy time per command, stop entry aborts it
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_q     <= 1'b0;
            start_q    <= 1'b0;
            cnt_q      <= '0;
            exe_cmd_q  <= `RST_BYTE;
            exe_addr_q <= '0;
            exe_data_q <= `RST_BYTE;
        end else if (ce_in) begin
            busy_q  <= busy_d;
            start_q <= start;
            cnt_q   <= start ? '0 : (busy_q ? cnt_q + CW'(1) : cnt_q);
            if (start) begin
                exe_cmd_q  <= go_direct ? seq_cmd_q  : buf_cmd_q;
                exe_addr_q <= go_direct ? seq_addr_q : buf_addr_q;
                exe_data_q <= go_direct ? seq_data_q : buf_data_q;
            end
        end
    end

    // Backdoor key writes and registered read data
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            key_wr_q   <= 1'b0;
            key_idx_q  <= 3'h0;
            key_data_q <= `RST_BYTE;
            rdata_q    <= `RST_BYTE;
        end else if (ce_in) begin
            key_wr_q <= key_wr;
            if (key_wr) begin
                key_idx_q  <= bus_addr_in[2:0];
                key_data_q <= bus_wdata_in;
            end
            if (bus_rd_in) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign bus_rdata_out           = rdata_q;
    assign flash_read_invalid_out  = key_steer;
    assign key_write_out           = key_wr_q && ce_in;
    assign key_index_out           = key_idx_q;
    assign key_data_out            = key_data_q;
    assign array_start_out         = start_q && ce_in;
    assign array_cmd_out           = exe_cmd_q;
    assign array_addr_out          = exe_addr_q;
    assign array_data_out          = exe_data_q;
    assign array_busy_out          = busy_q;
    assign flash_clock_divider_out = div_q;
    assign divider_loaded_out      = div_loaded_q;

endmodule

// [bench/flash_ctl_monitor.sv]
// Concurrent checks on the ports of the flash control block.
// Assumes ce_in high during checked traffic and EXEC_CYCLES of at least 8.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"
module flash_ctl_monitor (
    input wire logic                 ref_clk_in,
    input wire logic                 rstn_in,
    input wire logic                 ce_in,
    input wire flash_ctl_pkg::addr_t bus_addr_in,
    input wire logic                 bus_wr_in,
    input wire logic                 bus_rd_in,
    input wire flash_ctl_pkg::byte_t bus_wdata_in,
    input wire flash_ctl_pkg::byte_t bus_rdata_out,
    input wire logic                 stop_entry_in,
    input wire flash_ctl_pkg::addr_t vector_addr_in,
    input wire flash_ctl_pkg::addr_t vector_addr_out,
    input wire logic                 flash_read_invalid_out,
    input wire logic                 key_write_out,
    input wire logic [2:0]           key_index_out,
    input wire flash_ctl_pkg::byte_t key_data_out,
    input wire logic                 array_start_out,
    input wire logic                 array_busy_out,
    input wire logic                 divider_loaded_out
);
    import flash_ctl_pkg::*;
    // ----------------------------------------------------------------
    // Access decode and checks
    // ----------------------------------------------------------------
    wire logic       rd_acc  = bus_rd_in && ce_in;
    wire logic       key_acc = bus_wr_in && ce_in && bus_addr_in[15:3] == `KEY_BASE_HI;
    wire logic [2:0] key_idx = bus_addr_in[2:0];
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // Reserved bits read zero one cycle after the read edge
    AST_CFG_LOW: assert property (rd_acc && bus_addr_in == `ADDR_CONFIG
        |=> bus_rdata_out[4:0] == 5'h00) else $error("config low bits not zero");
    AST_PROT_LOW: assert property (rd_acc && bus_addr_in == `ADDR_PROTECT
        |=> bus_rdata_out[2:0] == 3'h0) else $error("protection low bits not zero");
    AST_STAT_LOW: assert property (rd_acc && bus_addr_in == `ADDR_STATUS
        |=> !bus_rdata_out[3] && bus_rdata_out[1:0] == 2'h0) else $error("status bits set");
    // Steered key writes carry index and data; unsteered ones never pulse
    AST_KEY_STEER: assert property (key_acc && flash_read_invalid_out |=> key_write_out
        && key_index_out == $past(key_idx) && key_data_out == $past(bus_wdata_in))
        else $error("key write not forwarded");
    AST_KEY_CMD: assert property (key_acc && !flash_read_invalid_out
        |=> !key_write_out) else $error("key pulse while steer clear");
    AST_DIV_SET: assert property (bus_wr_in && ce_in && bus_addr_in == `ADDR_DIVIDER
        |=> divider_loaded_out) else $error("divider flag not set");
    // A started command keeps the engine busy for at least eight cycles; stop entry may cut it
    AST_START_BUSY: assert property (disable iff (!rstn_in || stop_entry_in)
        array_start_out |-> array_busy_out[*8]) else $error("busy too short");
    AST_VEC_RESET: assert property (vector_addr_in[15:1] == 15'h7FFF
        |-> vector_addr_out == vector_addr_in) else $error("reset vector moved");
endmodule

// [bench/flash_bus_host.sv]
// Firmware and debug host model driving the flash register bus.
// Assumes the caller waits for completion; strobes are one cycle wide.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"
module flash_bus_host (
    input  wire logic                 ref_clk_in,
    output flash_ctl_pkg::addr_t      bus_addr_out,
    output logic                      bus_wr_out,
    output logic                      bus_rd_out,
    output logic                      bus_debug_out,
    output flash_ctl_pkg::byte_t      bus_wdata_out,
    input  wire flash_ctl_pkg::byte_t bus_rdata_in
);
    import flash_ctl_pkg::*;
    // ----------------------------------------------------------------
    // Bus cycles, driven at the falling edge
    // ----------------------------------------------------------------
    initial begin
        bus_addr_out  = 16'h0000;
        bus_wr_out    = 1'b0;
        bus_rd_out    = 1'b0;
        bus_debug_out = 1'b0;
        bus_wdata_out = 8'h00;
    end
    task automatic wr(input addr_t a, input byte_t d, input logic dbg = 1'b0);
        @(negedge ref_clk_in);
        bus_addr_out  = a;
        bus_wdata_out = d;
        bus_debug_out = dbg;
        bus_wr_out    = 1'b1;
        @(negedge ref_clk_in);
        bus_wr_out    = 1'b0;
        bus_debug_out = 1'b0;
        bus_wdata_out = ~d;   // Released data never shows the last value
    endtask
    // Read data stands one cycle after the read edge; sampled a cycle later
    task automatic rd(input addr_t a, output byte_t d);
        @(negedge ref_clk_in);
        bus_addr_out = a;
        bus_rd_out   = 1'b1;
        @(negedge ref_clk_in);
        bus_rd_out   = 1'b0;
        @(negedge ref_clk_in);
        d = bus_rdata_in;
    endtask
    // Target byte, then code, then launch by writing one to buffer empty
    task automatic launch(input addr_t a, input byte_t code);
        wr(a, 8'h5A);
        wr(`ADDR_COMMAND, code);
        wr(`ADDR_STATUS, 8'h80);
    endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the flash control block.
// Assumes the host model above; ce_in held high throughout.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"
module tb_top;
    import flash_ctl_pkg::*;
    // ----------------------------------------------------------------
    // Clock, nets and instances
    // ----------------------------------------------------------------
    logic       clk = 1'b0, rstn = 1'b0, redir = 1'b0, secured = 1'b0;
    logic       stop = 1'b0, erased = 1'b1;
    addr_t      vin = 16'hFFF0;
    addr_t      addr, vout, aaddr;
    byte_t      wdata, rdata, kdata, acmd, adata, got;
    logic       wr, rd, dbg, inval, kw, start, busy, divider_loaded;
    logic [2:0] kidx;
    int         err_total = 0;
    int         comparisons = 0;
    byte_t      codes[7] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h33, 8'h05};
    byte_t      imm[7]   = '{8'h00, 8'h00, 8'h80, 8'h00, 8'hE0, 8'hD0, 8'h00};
    byte_t      fin[7]   = '{8'hC4, 8'hC0, 8'hC0, 8'hC0, 8'hE0, 8'hD0, 8'hC0};
    always #5 clk = ~clk;
    flash_bus_host flash_bus_host_i (.ref_clk_in(clk), .bus_addr_out(addr), .bus_wr_out(wr),
        .bus_rd_out(rd), .bus_debug_out(dbg), .bus_wdata_out(wdata), .bus_rdata_in(rdata));
    flash_control_status_regs #(.SMALL_FLASH(1'b0), .EXEC_CYCLES(8))
        flash_control_status_regs_i (.ref_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1),
        .bus_addr_in(addr), .bus_wr_in(wr), .bus_rd_in(rd), .bus_debug_in(dbg),
        .bus_wdata_in(wdata), .bus_rdata_out(rdata), .stored_protection_byte_in(8'h4F),
        .redirection_disable_in(redir), .secured_in(secured), .stop_entry_in(stop),
        .array_erased_in(erased), .vector_addr_in(vin), .vector_addr_out(vout),
        .flash_read_invalid_out(inval), .key_write_out(kw), .key_index_out(kidx),
        .key_data_out(kdata), .array_start_out(start), .array_cmd_out(acmd),
        .array_addr_out(aaddr), .array_data_out(adata), .array_busy_out(busy),
        .flash_clock_divider_out(), .divider_loaded_out(divider_loaded));
    // Compare tasks, one per kind of value
    task automatic chk8(input byte_t g, input byte_t e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk16(input addr_t g, input addr_t e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t address %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input addr_t a, input byte_t e);
        flash_bus_host_i.rd(a, got);
        chk8(got, e);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under 3000 cycles
    initial begin
        #100000;
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        rdchk(`ADDR_PROTECT, 8'h48);
        flash_bus_host_i.wr(`ADDR_PROTECT, 8'hFF);
        rdchk(`ADDR_PROTECT, 8'h48);
        rdchk(`ADDR_STATUS, 8'hC0);
        flash_bus_host_i.wr(`ADDR_CONFIG, 8'hFF);
        rdchk(`ADDR_CONFIG, 8'hE0);
        flash_bus_host_i.wr(16'hFFB3, 8'h3C);
        chk8({5'h00, kidx}, 8'h03);
        chk8(kdata, 8'h3C);
        chk8({7'h00, inval}, 8'h01);
        flash_bus_host_i.wr(`ADDR_CONFIG, 8'h00);
        $display("test registers done");
        // Launch before the divider is loaded errors; zero write leaves flag
        flash_bus_host_i.launch(16'h8000, `CMD_BYTE_PROG);
        rdchk(`ADDR_STATUS, 8'hD0);
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h00);
        rdchk(`ADDR_STATUS, 8'hD0);
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h10);
        rdchk(`ADDR_STATUS, 8'hC0);
        flash_bus_host_i.wr(`ADDR_DIVIDER, 8'h13);
        chk8({7'h00, divider_loaded}, 8'h01);
        // Key address starts a command; open clear protects all of it
        flash_bus_host_i.launch(16'hFFB0, `CMD_BYTE_PROG);
        rdchk(`ADDR_STATUS, 8'hE0);
        flash_bus_host_i.wr(`ADDR_PROTECT, 8'h80, 1'b1);
        rdchk(`ADDR_PROTECT, 8'h80);
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h20);
        flash_bus_host_i.launch(16'hFE10, `CMD_BYTE_PROG);
        rdchk(`ADDR_STATUS, 8'hE0);
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h20);
        rdchk(`ADDR_STATUS, 8'hC0);
        secured = 1'b1;
        flash_bus_host_i.launch(16'h8000, `CMD_BYTE_PROG);
        rdchk(`ADDR_STATUS, 8'hE0);
        secured = 1'b0;
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h20);
        $display("test errors done");
        // Every command code, legal and not, on an open location
        for (int i = 0; i < 7; i++) begin
            erased = (i != 6);
            flash_bus_host_i.launch(16'h8000, codes[i]);
            rdchk(`ADDR_STATUS, imm[i]);
            if (i < 4) begin
                chk8(acmd, codes[i]);
                chk16(aaddr, 16'h8000);
                chk8(adata, 8'h5A);
            end
            for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk);
            @(negedge clk);
            rdchk(`ADDR_STATUS, fin[i]);
            flash_bus_host_i.wr(`ADDR_STATUS, 8'h30);
        end
        // Stop entry mid-command aborts it with an access error
        flash_bus_host_i.launch(16'h8000, `CMD_BYTE_PROG);
        stop = 1'b1;
        @(negedge clk);
        stop = 1'b0;
        chk8({7'h00, busy}, 8'h00);
        rdchk(`ADDR_STATUS, 8'hD0);
        flash_bus_host_i.wr(`ADDR_STATUS, 8'h10);
        $display("test commands done");
        // Block size table and vector redirection just below the block
        for (int s = 0; s < 8; s++) begin
            flash_bus_host_i.wr(`ADDR_PROTECT, {2'b10, s[2:0], 3'b000}, 1'b1);
            chk16(vout, (s >= 6) ? 16'h7FF0 : 16'hFFF0 - (16'h0200 << s));
        end
        vin = 16'hFFFE;
        @(negedge clk);
        chk16(vout, 16'hFFFE);
        vin = 16'hFFF0;
        redir = 1'b1;
        @(negedge clk);
        chk16(vout, 16'hFFF0);
        redir = 1'b0;
        flash_bus_host_i.wr(`ADDR_PROTECT, 8'hC0, 1'b1);
        chk16(vout, 16'hFFF0);
        flash_bus_host_i.wr(`ADDR_PROTECT, 8'h00, 1'b1);
        chk16(vout, 16'hFFF0);
        $display("test redirection done");
        // A second reset reloads protection and forgets the divider write
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        chk8({7'h00, divider_loaded}, 8'h00);
        rdchk(`ADDR_PROTECT, 8'h48);
        $display("test reset done");
        wrap_up();
    end
endmodule
bind flash_control_status_regs flash_ctl_monitor flash_ctl_monitor_i (.*);
